// ===== src/dic_card.sv
// Digital input/interrupt card: edge latch, interrupt byte, 16-bit handshaked input, display
// Summary of operation
// - Writing the enable mask selects, bit n for channel n, which channels may interrupt.
// - Channels whose sense bit is set watch rising edges, the other channels of 0 to 7 watch falling edges.
// - The card interrupt exists only when the card sits in main slot 0 to 4.
// - Reading the interrupt byte returns the set bits of that byte, zero when nothing flagged.
// - A card interrupt sets bit 1 of the mainframe status byte.
// - Input reads return the input word, only the interrupt query returns the interrupt byte.
// - An input reading is a 16-bit value, channel n in bit n.
// - The continuous read keeps delivering readings, the single read delivers exactly one.
// - Input reads work in slots 0 to 4 and 10 to 89 and are refused elsewhere.
// - The display shows the slot as three digits and the data as six octal digits, indicator lit.
// - A detected edge of the chosen sense sets the channel's input-byte bit.
// - An interrupt-byte bit is set only while its input-byte bit and enable bit are both set.
// - With handshake on, a read command drives the gate output to ready.
// - A low-to-high flag, or high-to-low with the flag-fall bit set, captures the data and returns the gate to busy in single reads; continuous reads keep it ready.
`timescale 1ns/10ps
module dic_card
  import dic_pkg::*;
#(
  parameter int CONT_GAP_CYC = DIC_CONT_GAP_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic [31:0] write_data,
  input wire logic write_strobe,
  input wire logic read_strobe,
  output logic [31:0] read_data,
  input wire logic [6:0] slot_id,
  input wire logic [DIC_DATA_W-1:0] chan_in,
  input wire logic flag_in,
  output logic gate_ready,
  output logic reading_valid,
  output logic [7:0] status_byte,
  output logic card_irq,
  output logic irq,
  output logic [DIC_DISP_SLOT_W-1:0] disp_slot,
  output logic [DIC_DISP_VAL_W-1:0] disp_value,
  output logic octal_indicator
);

  // The gap counter is 16 bits wide and a zero gap would wrap its reload value to 65535
  if (CONT_GAP_CYC < 1 || CONT_GAP_CYC > 65535) begin : g_bad_gap
    $error("dic_card: CONT_GAP_CYC out of range");
  end

  typedef struct packed {
    logic [DIC_BYTE_W-1:0] en_mask;
    logic [DIC_BYTE_W-1:0] sense;
    logic [DIC_BYTE_W-1:0] in_byte;
    logic [DIC_BYTE_W-1:0] int_byte;
    logic [DIC_DATA_W-1:0] chan_prev;
    logic flag_prev;
    logic [DIC_DATA_W-1:0] data;
    logic hs_en;
    logic flag_fall;
    logic cont;
    logic refused;
    logic [15:0] gap_cnt;
    logic gate_ready;
    logic reading_valid;
    logic card_int;
    logic [DIC_IRQ_W-1:0] irq_st;
    logic [DIC_IRQ_W-1:0] irq_mask;
    logic irq;
    logic [31:0] rdata;
    logic [DIC_DISP_SLOT_W-1:0] disp_slot;
    logic [DIC_DISP_VAL_W-1:0] disp_value;
    logic octal_ind;
  } dic_regs_t;

  dic_regs_t s_r;
  dic_regs_t s_nxt;
  dic_state_t state_r;
  dic_state_t state_nxt;

  // Per-channel edge detect for the eight interrupt-capable channels
  logic [DIC_BYTE_W-1:0] edge_hit;
  genvar gi;
  generate
    for (gi = 0; gi < DIC_BYTE_W; gi++) begin : g_edge
      assign edge_hit[gi] = s_r.sense[gi] ? (chan_in[gi] & ~s_r.chan_prev[gi]) :
                                            (~chan_in[gi] & s_r.chan_prev[gi]);
    end
  endgenerate

  logic main_slot;
  logic input_slot;
  logic flag_edge;
  logic wr_en;
  logic wr_cmd;
  logic cmd_go;
  logic capture;
  logic [DIC_BYTE_W-1:0] in_clr;
  logic [DIC_BYTE_W-1:0] in_new;
  logic [DIC_BYTE_W-1:0] int_new;
  logic [DIC_IRQ_W-1:0] ev;
  logic [DIC_IRQ_W-1:0] st_clr;
  logic [6:0] tens;
  logic [6:0] ones;

  always_comb begin
    main_slot = (slot_id <= DIC_MAIN_SLOT_MAX);
    input_slot = main_slot || ((slot_id >= DIC_EXT_SLOT_MIN) &&
                               (slot_id <= DIC_EXT_SLOT_MAX));
    flag_edge = s_r.flag_fall ? (s_r.flag_prev & ~flag_in) : (flag_in & ~s_r.flag_prev);
    wr_en = write_strobe;
    wr_cmd = wr_en && (address == DIC_ADDR_CMD);
    cmd_go = wr_cmd && (write_data[DIC_CMD_CONT] || write_data[DIC_CMD_SINGLE]);
    tens = slot_id / 7'd10;
    ones = slot_id - 7'((tens * 7'd10));
  end

  always_comb begin
    s_nxt = s_r;
    state_nxt = state_r;
    capture = 1'b0;
    ev = '0;
    s_nxt.chan_prev = chan_in;
    s_nxt.flag_prev = flag_in;
    s_nxt.reading_valid = 1'b0;

    // Register writes
    if (wr_en && address == DIC_ADDR_EN_MASK) begin
      s_nxt.en_mask = write_data[DIC_BYTE_W-1:0];
    end
    if (wr_en && address == DIC_ADDR_SENSE) begin
      s_nxt.sense = write_data[DIC_BYTE_W-1:0];
    end
    if (wr_en && address == DIC_ADDR_CFG) begin
      s_nxt.hs_en = write_data[DIC_CFG_HS_EN];
      s_nxt.flag_fall = write_data[DIC_CFG_FLAG_FALL];
    end
    if (wr_en && address == DIC_ADDR_IRQ_MASK) begin
      s_nxt.irq_mask = write_data[DIC_IRQ_W-1:0];
    end

    // Input byte: edges set, write-one clears; a new edge wins over the clear
    in_clr = (wr_en && address == DIC_ADDR_IN_BYTE) ? write_data[DIC_BYTE_W-1:0] : '0;
    in_new = (s_r.in_byte & ~in_clr) | edge_hit;
    s_nxt.in_byte = in_new;
    int_new = in_new & s_nxt.en_mask;
    s_nxt.int_byte = int_new;
    if (|int_new && !(|s_r.int_byte)) begin
      ev[DIC_IRQ_CHAN] = 1'b1;
    end
    // Only main slots have a wire to the mainframe interrupt line
    s_nxt.card_int = (|int_new) && main_slot;

    // Read sequencer
    case (state_r)
      DIC_IDLE: begin
        if (cmd_go) begin
          if (!input_slot) begin
            s_nxt.refused = 1'b1;
            ev[DIC_IRQ_REFUSED] = 1'b1;
          end else begin
            s_nxt.refused = 1'b0;
            s_nxt.cont = write_data[DIC_CMD_CONT];
            if (s_r.hs_en) begin
              s_nxt.gate_ready = 1'b1;
              state_nxt = DIC_WAIT_FLAG;
            end else begin
              capture = 1'b1;
            end
          end
        end
      end
      DIC_WAIT_FLAG: begin
        if (flag_edge) begin
          s_nxt.gate_ready = 1'b0;
          capture = 1'b1;
        end
      end
      DIC_GAP: begin
        if (s_r.gap_cnt == 16'h0000) begin
          capture = 1'b1;
        end else begin
          s_nxt.gap_cnt = s_r.gap_cnt - 16'h0001;
        end
      end
      default: begin
        state_nxt = DIC_IDLE;
      end
    endcase

    if (capture) begin
      s_nxt.data = chan_in;
      s_nxt.reading_valid = 1'b1;
      ev[DIC_IRQ_READING] = 1'b1;
      s_nxt.disp_value = DIC_DISP_VAL_W'(chan_in);
      // Continuous mode re-arms; single mode ends after one reading
      if (s_nxt.cont) begin
        if (s_r.hs_en) begin
          state_nxt = DIC_WAIT_FLAG;
        end else begin
          s_nxt.gap_cnt = 16'(CONT_GAP_CYC - 1);
          state_nxt = DIC_GAP;
        end
      end else begin
        state_nxt = DIC_IDLE;
      end
    end
    // Handshake: ready again for the next continuous word
    if (capture && s_nxt.cont && s_r.hs_en) begin
      s_nxt.gate_ready = 1'b1;
    end

    // Stop ends a continuous read at once
    if (wr_cmd && write_data[DIC_CMD_STOP]) begin
      s_nxt.cont = 1'b0;
      s_nxt.gate_ready = 1'b0;
      state_nxt = DIC_IDLE;
    end

    // Sticky events, write-one-to-clear; set wins
    st_clr = (wr_en && address == DIC_ADDR_IRQ_ST) ? write_data[DIC_IRQ_W-1:0] : '0;
    s_nxt.irq_st = (s_r.irq_st & ~st_clr) | ev;
    s_nxt.irq = |(s_nxt.irq_st & s_nxt.irq_mask);

    // Display: three-digit slot, six octal digits of the requested value
    s_nxt.disp_slot = {4'h0, tens[3:0], ones[3:0]};
    s_nxt.octal_ind = 1'b1;

    // Register reads, data valid in the next cycle only
    s_nxt.rdata = '0;
    if (read_strobe) begin
      case (address)
        DIC_ADDR_EN_MASK: s_nxt.rdata = 32'(s_r.en_mask);
        DIC_ADDR_SENSE: s_nxt.rdata = 32'(s_r.sense);
        DIC_ADDR_IN_BYTE: s_nxt.rdata = 32'(s_r.in_byte);
        DIC_ADDR_INT_BYTE: begin
          s_nxt.rdata = 32'(s_r.int_byte);
          s_nxt.disp_value = DIC_DISP_VAL_W'(s_r.int_byte);
        end
        DIC_ADDR_DATA: s_nxt.rdata = 32'(s_r.data);
        DIC_ADDR_CFG: s_nxt.rdata = 32'({s_r.flag_fall, s_r.hs_en});
        DIC_ADDR_STATUS: s_nxt.rdata = 32'({s_r.refused, s_r.cont, s_r.gate_ready,
                                             s_r.card_int});
        DIC_ADDR_IRQ_ST: s_nxt.rdata = 32'(s_r.irq_st);
        DIC_ADDR_IRQ_MASK: s_nxt.rdata = 32'(s_r.irq_mask);
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_r <= '0;
      s_r.en_mask <= DIC_EN_MASK_RST;
      s_r.sense <= DIC_SENSE_RST;
      s_r.hs_en <= DIC_CFG_RST[DIC_CFG_HS_EN];
      s_r.flag_fall <= DIC_CFG_RST[DIC_CFG_FLAG_FALL];
      s_r.irq_mask <= DIC_IRQ_MASK_RST;
      state_r <= DIC_IDLE;
    end else begin
      s_r <= s_nxt;
      state_r <= state_nxt;
    end
  end

  assign read_data = s_r.rdata;
  assign gate_ready = s_r.gate_ready;
  assign reading_valid = s_r.reading_valid;
  // Status byte toward the mainframe carries only the digital-interrupt bit from this card
  assign status_byte = {6'h00, s_r.card_int, 1'b0};
  assign card_irq = s_r.card_int;
  assign irq = s_r.irq;
  assign disp_slot = s_r.disp_slot;
  assign disp_value = s_r.disp_value;
  assign octal_indicator = s_r.octal_ind;

endmodule : dic_card

// ===== src/dic_pkg.sv
// Package: register map, field positions and constants of the digital input/interrupt card
package dic_pkg;
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] DIC_ADDR_EN_MASK = 8'h00;
  localparam logic [7:0] DIC_ADDR_SENSE = 8'h04;
  localparam logic [7:0] DIC_ADDR_IN_BYTE = 8'h08;
  localparam logic [7:0] DIC_ADDR_INT_BYTE = 8'h0C;
  localparam logic [7:0] DIC_ADDR_DATA = 8'h10;
  localparam logic [7:0] DIC_ADDR_CFG = 8'h14;
  localparam logic [7:0] DIC_ADDR_CMD = 8'h18;
  localparam logic [7:0] DIC_ADDR_STATUS = 8'h1C;
  localparam logic [7:0] DIC_ADDR_IRQ_ST = 8'h20;
  localparam logic [7:0] DIC_ADDR_IRQ_MASK = 8'h24;
  // CFG fields
  localparam int DIC_CFG_HS_EN = 0;
  localparam int DIC_CFG_FLAG_FALL = 1;
  // CMD fields (write-only, self clearing)
  localparam int DIC_CMD_CONT = 0;
  localparam int DIC_CMD_SINGLE = 1;
  localparam int DIC_CMD_STOP = 2;
  // STATUS fields
  localparam int DIC_ST_CARD_INT = 0;
  localparam int DIC_ST_GATE_READY = 1;
  localparam int DIC_ST_CONT = 2;
  localparam int DIC_ST_REFUSED = 3;
  // IRQ status / mask fields
  localparam int DIC_IRQ_READING = 0;
  localparam int DIC_IRQ_CHAN = 1;
  localparam int DIC_IRQ_REFUSED = 2;
  localparam int DIC_IRQ_W = 3;
  // Mainframe status byte: digital interrupt bit
  localparam int DIC_STB_DIGITAL = 1;
  // Slot ranges
  localparam logic [6:0] DIC_MAIN_SLOT_MAX = 7'h04;
  localparam logic [6:0] DIC_EXT_SLOT_MIN = 7'h0A;
  localparam logic [6:0] DIC_EXT_SLOT_MAX = 7'h59;
  // Reset values
  localparam logic [7:0] DIC_EN_MASK_RST = 8'h00;
  localparam logic [7:0] DIC_SENSE_RST = 8'h00;
  localparam logic [1:0] DIC_CFG_RST = 2'h0;
  localparam logic [DIC_IRQ_W-1:0] DIC_IRQ_MASK_RST = 3'h0;
  // Data widths
  localparam int DIC_DATA_W = 16;
  localparam int DIC_BYTE_W = 8;
  localparam int DIC_DISP_VAL_W = 18;
  localparam int DIC_DISP_SLOT_W = 12;
  // Continuous reads without handshake: spacing between readings
  localparam int DIC_CLK_NS = 10;
  localparam int DIC_CONT_GAP_NS = 1000;
  localparam int DIC_CONT_GAP_CYC = DIC_CONT_GAP_NS / DIC_CLK_NS;

  typedef enum {
    DIC_IDLE,
    DIC_WAIT_FLAG,
    DIC_GAP
  } dic_state_t;
endpackage : dic_pkg

// ===== tb/dic_card_asserts.sv
// Port-level checks of the digital input/interrupt card
`timescale 1ns/10ps
module dic_card_asserts
  import dic_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] address,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic [31:0] read_data,
  input wire logic [6:0] slot_id,
  input wire logic [15:0] chan_in,
  input wire logic flag_in,
  input wire logic gate_ready,
  input wire logic reading_valid,
  input wire logic [7:0] status_byte,
  input wire logic card_irq,
  input wire logic [11:0] disp_slot,
  input wire logic [17:0] disp_value,
  input wire logic octal_indicator
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_stb_mirror: assert property (status_byte == {6'h00, card_irq, 1'b0})
    else $error("status byte does not follow card interrupt");
  a_irq_slot: assert property (card_irq |-> $past(slot_id) <= DIC_MAIN_SLOT_MAX)
    else $error("card interrupt outside main slots");
  a_irq_cause: assert property ($rose(card_irq) |-> $past(write_strobe) ||
    $past(slot_id) != $past(slot_id, 2) ||
    $past(chan_in[7:0]) != $past(chan_in[7:0], 2)) else $error("card interrupt without edge");
  a_flag_capture: assert property (gate_ready && $rose(flag_in) |=> reading_valid)
    else $error("flag edge while ready gave no reading");
  a_reading_pulse: assert property (reading_valid |=> !reading_valid)
    else $error("reading pulse longer than one cycle");
  a_octal_lit: assert property ($past(reset_n) |-> octal_indicator)
    else $error("octal indicator dark");
  a_slot_digits: assert property ($past(reset_n) |-> disp_slot == {4'h0,
    4'($past(slot_id) / 7'h0A), 4'($past(slot_id) % 7'h0A)}) else $error("slot display wrong");
  a_int_query: assert property ($past(read_strobe) && $past(address) == DIC_ADDR_INT_BYTE
    |-> disp_value == read_data[17:0] && read_data[31:8] == 24'h00_0000)
    else $error("interrupt byte query wrong");
  a_read_idle: assert property (!$past(read_strobe) |-> read_data == 32'h0000_0000)
    else $error("read data outside its cycle");
  c_reading: cover property (reading_valid);
  c_card_irq: cover property ($rose(card_irq));
  c_gate: cover property ($rose(gate_ready));
endmodule : dic_card_asserts

bind dic_card dic_card_asserts u_chk (.clock(clock), .reset_n(reset_n), .address(address),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .slot_id(slot_id), .chan_in(chan_in), .flag_in(flag_in), .gate_ready(gate_ready),
  .reading_valid(reading_valid), .status_byte(status_byte), .card_irq(card_irq),
  .disp_slot(disp_slot), .disp_value(disp_value), .octal_indicator(octal_indicator));

// ===== tb/dic_source.sv
// Data source model: switch channels and a data-valid flag answering the gate
`timescale 1ns/10ps
module dic_source (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic gate_ready,
  input wire logic [15:0] word,
  input wire logic [3:0] delay,
  output logic [15:0] chan_in,
  output logic flag_in
);
  logic [3:0] cnt_r;
  always @(posedge clock) begin
    chan_in <= word;
    if (!reset_n || !gate_ready) begin
      cnt_r <= 4'h0;
      flag_in <= 1'b0;
    end else if (cnt_r == delay) begin
      // Word was stable before the flag rises
      flag_in <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : dic_source

// ===== tb/test_dic_card.sv
// Self-checking bench of the digital input/interrupt card
`timescale 1ns/10ps
module test_dic_card;
  import dic_pkg::*;
  localparam logic [31:0] ONE = 32'h0000_0001;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] write_data = 32'h0000_0000;
  logic [31:0] read_data, rd_v;
  logic write_strobe = 1'b0;
  logic read_strobe = 1'b0;
  logic [6:0] slot_id = 7'h03;
  logic [15:0] word = 16'h0080;
  logic [15:0] chan_in;
  logic flag_in, gate_ready, reading_valid, card_irq, irq;
  logic [7:0] status_byte;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  int n_rv = 0;
  always #5 clock = ~clock;
  dic_card #(.CONT_GAP_CYC(4)) dut (.clock(clock), .reset_n(reset_n), .address(address),
    .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .read_data(read_data), .slot_id(slot_id), .chan_in(chan_in), .flag_in(flag_in),
    .gate_ready(gate_ready), .reading_valid(reading_valid), .status_byte(status_byte),
    .card_irq(card_irq), .irq(irq), .disp_slot(), .disp_value(), .octal_indicator());
  dic_source u_src (.clock(clock), .reset_n(reset_n), .gate_ready(gate_ready), .word(word),
    .delay(4'h3), .chan_in(chan_in), .flag_in(flag_in));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cyc++;
    if (reading_valid === 1'b1) n_rv++;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 rd_v = read_data;
  endtask : rd
  task automatic t_regs;
    logic [7:0] ra [5] = '{DIC_ADDR_EN_MASK, DIC_ADDR_SENSE, DIC_ADDR_CFG, DIC_ADDR_IRQ_MASK, 8'h3C};
    wr(8'h3C, 32'hFFFF_FFFF);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", 32'h0000_0000, rd_v);
    end
  endtask : t_regs
  task automatic t_intr;
    wr(DIC_ADDR_EN_MASK, 32'h0000_0024);
    wr(DIC_ADDR_SENSE, 32'h0000_0024);
    wr(DIC_ADDR_IRQ_MASK, 32'h0000_0002);
    word <= 16'h0004;
    step(4);
    chk("card_irq", ONE, 32'(card_irq));
    chk("status_byte", 32'h0000_0002, 32'(status_byte));
    chk("irq", ONE, 32'(irq));
    rd(DIC_ADDR_INT_BYTE);
    chk("int byte", 32'h0000_0004, rd_v);
    rd(DIC_ADDR_IN_BYTE);
    chk("input byte", 32'h0000_0084, rd_v);
    wr(DIC_ADDR_IRQ_MASK, 32'h0000_0000);
    wr(DIC_ADDR_IN_BYTE, 32'h0000_00FF);
    wr(DIC_ADDR_IRQ_ST, 32'h0000_0007);
    word <= 16'h0020;
    step(4);
    rd(DIC_ADDR_INT_BYTE);
    chk("int byte", 32'h0000_0020, rd_v);
    chk("masked irq", 32'h0000_0000, 32'(irq));
    rd(DIC_ADDR_IRQ_ST);
    chk("irq status", 32'h0000_0002, rd_v);
  endtask : t_intr
  task automatic t_slot;
    slot_id <= 7'h09;
    word <= 16'h0004;
    step(4);
    chk("card_irq slot 9", 32'h0000_0000, 32'(card_irq));
    wr(DIC_ADDR_CMD, 32'h0000_0002);
    step(3);
    rd(DIC_ADDR_STATUS);
    chk("refused", ONE, 32'(rd_v[DIC_ST_REFUSED]));
    slot_id <= 7'h59;
    word <= 16'hFFFF;
    wr(DIC_ADDR_CMD, 32'h0000_0002);
    step(2);
    rd(DIC_ADDR_DATA);
    chk("data slot 89", 32'h0000_FFFF, rd_v);
    wr(DIC_ADDR_IN_BYTE, 32'h0000_00FF);
    slot_id <= 7'h02;
  endtask : t_slot
  task automatic t_hs;
    int n0;
    wr(DIC_ADDR_CFG, 32'h0000_0001);
    word <= 16'h5A3C;
    n0 = n_rv;
    wr(DIC_ADDR_CMD, 32'h0000_0002);
    step(1);
    chk("gate ready", ONE, 32'(gate_ready));
    for (int i = 0; i < 20 && reading_valid !== 1'b1; i++) step(1);
    chk("gate busy", 32'h0000_0000, 32'(gate_ready));
    rd(DIC_ADDR_DATA);
    chk("captured word", 32'h0000_5A3C, rd_v);
    step(20);
    chk("single count", ONE, 32'(n_rv - n0));
  endtask : t_hs
  task automatic t_cont;
    int n0;
    wr(DIC_ADDR_CFG, 32'h0000_0000);
    n0 = n_rv;
    wr(DIC_ADDR_CMD, 32'h0000_0001);
    step(30);
    wr(DIC_ADDR_CMD, 32'h0000_0004);
    chk("repeats", ONE, 32'(n_rv - n0 >= 6));
    step(2);
    n0 = n_rv;
    step(20);
    chk("stopped", 32'h0000_0000, 32'(n_rv - n0));
  endtask : t_cont
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_intr();
    t_slot();
    t_hs();
    t_cont();
    finish_test();
  end
endmodule : test_dic_card
